/* File: rtl/bsf_map.vh */
// constants for the bit, shift and flag instruction executor
`ifndef BSF_MAP_VH
`define BSF_MAP_VH
// operation codes on op_code_in
`define BSF_OP_NOP 5'h00
`define BSF_OP_EXT_PROG_LOAD 5'h01
`define BSF_OP_PROG_MEM_STORE 5'h02
`define BSF_OP_PORT_IN 5'h03
`define BSF_OP_PORT_OUT 5'h04
`define BSF_OP_PUSH 5'h05
`define BSF_OP_POP 5'h06
`define BSF_OP_IO_BIT_SET 5'h07
`define BSF_OP_IO_BIT_CLEAR 5'h08
`define BSF_OP_LOGIC_SHIFT_LEFT 5'h09
`define BSF_OP_LOGIC_SHIFT_RIGHT 5'h0A
`define BSF_OP_ROTATE_LEFT_CARRY 5'h0B
`define BSF_OP_ROTATE_RIGHT_CARRY 5'h0C
`define BSF_OP_ARITH_SHIFT_RIGHT 5'h0D
`define BSF_OP_NIBBLE_SWAP 5'h0E
`define BSF_OP_STATUS_BIT_SET 5'h0F
`define BSF_OP_STATUS_BIT_CLEAR 5'h10
`define BSF_OP_BIT_TO_TRANSFER_FLAG 5'h11
`define BSF_OP_TRANSFER_FLAG_TO_BIT 5'h12
`define BSF_OP_CARRY_SET 5'h13
`define BSF_OP_CARRY_CLEAR 5'h14
`define BSF_OP_NEGATIVE_SET 5'h15
`define BSF_OP_NEGATIVE_CLEAR 5'h16
`define BSF_OP_ZERO_FLAG_SET 5'h17
`define BSF_OP_ZERO_FLAG_CLEAR 5'h18
`define BSF_OP_IRQ_ENABLE_SET 5'h19
`define BSF_OP_IRQ_ENABLE_CLEAR 5'h1A
// status register bit positions
`define BSF_FLAG_C 0
`define BSF_FLAG_Z 1
`define BSF_FLAG_N 2
`define BSF_FLAG_V 3
`define BSF_FLAG_S 4
`define BSF_FLAG_H 5
`define BSF_FLAG_T 6
`define BSF_FLAG_I 7
// reset values
`define BSF_STATUS_RESET 8'h00
`define BSF_EXT_RESET 8'h00
// cycle counts per instruction
`define BSF_CYC_EXT_LOAD 2'h3
`define BSF_CYC_TWO 2'h2
`define BSF_CYC_ONE 2'h1
`endif

/* File: rtl/bsf_shift_unit.v */
// shift, rotate and swap datapath with flag results
`timescale 1ns/10ps
module bsf_shift_unit (
  // operation select
  input wire [4:0] op_in,
  // operand and incoming flags
  input wire [7:0] operand_in,
  input wire carry_in,
  // result and flags
  output reg [7:0] result_out,
  output reg carry_out,
  output wire zero_out,
  output wire negative_out,
  output wire overflow_out,
  output wire sign_out
);
`include "bsf_map.vh"

  always @* begin
    result_out = operand_in;
    carry_out = carry_in;
    case (op_in)
      `BSF_OP_LOGIC_SHIFT_LEFT: begin
        result_out = {operand_in[6:0], 1'b0};
        carry_out = operand_in[7];
      end
      `BSF_OP_LOGIC_SHIFT_RIGHT: begin
        result_out = {1'b0, operand_in[7:1]};
        carry_out = operand_in[0];
      end
      `BSF_OP_ROTATE_LEFT_CARRY: begin
        result_out = {operand_in[6:0], carry_in};
        carry_out = operand_in[7];
      end
      `BSF_OP_ROTATE_RIGHT_CARRY: begin
        result_out = {carry_in, operand_in[7:1]};
        carry_out = operand_in[0];
      end
      `BSF_OP_ARITH_SHIFT_RIGHT: begin
        result_out = {operand_in[7], operand_in[7:1]};
        carry_out = operand_in[0];
      end
      `BSF_OP_NIBBLE_SWAP: begin
        result_out = {operand_in[3:0], operand_in[7:4]};
      end
      default: begin
        result_out = operand_in;
        carry_out = carry_in;
      end
    endcase
  end

  assign zero_out = (result_out == 8'h00);
  assign negative_out = result_out[7];
  // shifts define overflow as negative xor carry
  assign overflow_out = result_out[7] ^ carry_out;
  assign sign_out = negative_out ^ overflow_out;
endmodule // bsf_shift_unit

/* File: rtl/bsf_exec.v */
// executor for bit, shift, flag, port, stack and program-memory ops
// How it works
// - extended load reads ext:Z, increments, three cycles
// - store writes R1:R0 word at Z
// - port in/out copy byte, one cycle
// - push stores source on stack, two cycles
// - pop loads destination from stack, two cycles
// - io bit set/clear touches one bit, two cycles
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - status bit s set or cleared alone
// - source bit b copied into transfer flag
// - transfer flag copied into destination bit b
// - dedicated flag set/clear for C,N,Z,I
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module bsf_exec (
  // clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // instruction issue
  input wire op_valid_in,
  input wire [4:0] op_code_in,
  input wire [2:0] bit_sel_in,
  input wire [5:0] io_addr_in,
  output wire op_ready_out,
  output reg op_done_out,
  // register file operands
  input wire [7:0] reg_src_in,
  input wire [7:0] reg_dst_in,
  input wire [15:0] z_ptr_in,
  input wire [15:0] r1r0_word_in,
  output reg reg_wr_out,
  output reg [7:0] reg_wr_data_out,
  output reg z_wr_out,
  output reg [15:0] z_wr_data_out,
  // program memory
  output reg pm_rd_out,
  output reg pm_wr_out,
  output reg [23:0] pm_addr_out,
  output reg [15:0] pm_wr_data_out,
  input wire [7:0] pm_rd_data_in,
  // io space
  output reg io_rd_out,
  output reg io_wr_out,
  output reg [5:0] io_addr_out,
  output reg [7:0] io_wr_data_out,
  input wire [7:0] io_rd_data_in,
  // stack
  output reg stack_push_out,
  output reg stack_pop_out,
  output reg [7:0] stack_wr_data_out,
  input wire [7:0] stack_rd_data_in,
  // extension register load and state
  input wire ext_wr_in,
  input wire [7:0] ext_wr_data_in,
  output wire [7:0] prog_addr_extension_out,
  output wire [7:0] status_register_out
);
`include "bsf_map.vh"

  // one-hot: idle takes ops, wait pads the extended load,
  // last finishes every multi-cycle op
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_LAST = 3'b100;

  reg [2:0] state_reg;
  reg [1:0] cnt_reg;
  reg [4:0] op_reg;
  reg [2:0] bit_reg;
  reg [5:0] io_reg;
  reg [7:0] status_reg;
  reg [7:0] ext_reg;
  reg [7:0] status_next;
  wire [7:0] sh_result;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;
  wire sh_s;
  wire take;
  wire [23:0] ext_ptr;
  wire [23:0] ext_ptr_inc;

  // one-hot bit decode, used for io bits and status bits alike
  function [7:0] onehot8;
    input [2:0] sel;
    begin
      onehot8 = 8'h01 << sel;
    end
  endfunction

  // multi-cycle ops take a fixed count; everything else one cycle
  function [1:0] cycles_of;
    input [4:0] op;
    begin
      if (op == `BSF_OP_EXT_PROG_LOAD) begin
        cycles_of = `BSF_CYC_EXT_LOAD;
      end else if (op == `BSF_OP_PUSH || op == `BSF_OP_POP ||
                   op == `BSF_OP_IO_BIT_SET ||
                   op == `BSF_OP_IO_BIT_CLEAR) begin
        cycles_of = `BSF_CYC_TWO;
      end else begin
        cycles_of = `BSF_CYC_ONE;
      end
    end
  endfunction

  assign op_ready_out = state_reg[0];
  assign take = op_valid_in && op_ready_out;
  assign status_register_out = status_reg;
  assign prog_addr_extension_out = ext_reg;
  assign ext_ptr = {ext_reg, z_ptr_in};
  // 24-bit increment so a Z wrap carries into the extension
  assign ext_ptr_inc = ext_ptr + 24'h000001;

  bsf_shift_unit u_shift (
    .op_in(op_code_in),
    .operand_in(reg_dst_in),
    .carry_in(status_reg[`BSF_FLAG_C]),
    .result_out(sh_result),
    .carry_out(sh_c),
    .zero_out(sh_z),
    .negative_out(sh_n),
    .overflow_out(sh_v),
    .sign_out(sh_s)
  );

  ////////////////////////////////////////////////////////////////////
  // single-cycle flag updates
  always @* begin
    status_next = status_reg;
    if (take) begin
      case (op_code_in)
        `BSF_OP_LOGIC_SHIFT_LEFT,
        `BSF_OP_LOGIC_SHIFT_RIGHT,
        `BSF_OP_ROTATE_LEFT_CARRY,
        `BSF_OP_ROTATE_RIGHT_CARRY,
        `BSF_OP_ARITH_SHIFT_RIGHT: begin
          status_next[`BSF_FLAG_C] = sh_c;
          status_next[`BSF_FLAG_Z] = sh_z;
          status_next[`BSF_FLAG_N] = sh_n;
          status_next[`BSF_FLAG_V] = sh_v;
          // sign follows n^v, kept coherent with the other flags
          status_next[`BSF_FLAG_S] = sh_s;
        end
        `BSF_OP_STATUS_BIT_SET: begin
          status_next = status_reg | onehot8(bit_sel_in);
        end
        `BSF_OP_STATUS_BIT_CLEAR: begin
          status_next = status_reg & ~onehot8(bit_sel_in);
        end
        `BSF_OP_BIT_TO_TRANSFER_FLAG: begin
          status_next[`BSF_FLAG_T] = reg_src_in[bit_sel_in];
        end
        `BSF_OP_CARRY_SET: begin
          status_next[`BSF_FLAG_C] = 1'b1;
        end
        `BSF_OP_CARRY_CLEAR: begin
          status_next[`BSF_FLAG_C] = 1'b0;
        end
        `BSF_OP_NEGATIVE_SET: begin
          status_next[`BSF_FLAG_N] = 1'b1;
        end
        `BSF_OP_NEGATIVE_CLEAR: begin
          status_next[`BSF_FLAG_N] = 1'b0;
        end
        `BSF_OP_ZERO_FLAG_SET: begin
          status_next[`BSF_FLAG_Z] = 1'b1;
        end
        `BSF_OP_ZERO_FLAG_CLEAR: begin
          status_next[`BSF_FLAG_Z] = 1'b0;
        end
        `BSF_OP_IRQ_ENABLE_SET: begin
          status_next[`BSF_FLAG_I] = 1'b1;
        end
        `BSF_OP_IRQ_ENABLE_CLEAR: begin
          status_next[`BSF_FLAG_I] = 1'b0;
        end
        default: begin
          status_next = status_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer and datapath strobes
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      op_reg <= `BSF_OP_NOP;
      bit_reg <= 3'h0;
      io_reg <= 6'h00;
      status_reg <= `BSF_STATUS_RESET;
      ext_reg <= `BSF_EXT_RESET;
      op_done_out <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_wr_data_out <= 8'h00;
      z_wr_out <= 1'b0;
      z_wr_data_out <= 16'h0000;
      pm_rd_out <= 1'b0;
      pm_wr_out <= 1'b0;
      pm_addr_out <= 24'h000000;
      pm_wr_data_out <= 16'h0000;
      io_rd_out <= 1'b0;
      io_wr_out <= 1'b0;
      io_addr_out <= 6'h00;
      io_wr_data_out <= 8'h00;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      stack_wr_data_out <= 8'h00;
    end else begin
      status_reg <= status_next;
      op_done_out <= 1'b0;
      reg_wr_out <= 1'b0;
      z_wr_out <= 1'b0;
      pm_rd_out <= 1'b0;
      pm_wr_out <= 1'b0;
      io_rd_out <= 1'b0;
      io_wr_out <= 1'b0;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      // the executor's own increment wins over a software load
      if (ext_wr_in) begin
        ext_reg <= ext_wr_data_in;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            op_reg <= op_code_in;
            bit_reg <= bit_sel_in;
            io_reg <= io_addr_in;
            io_addr_out <= io_addr_in;
            cnt_reg <= cycles_of(op_code_in) - 2'h1;
            // flags of single-cycle ops land on this same edge
            case (op_code_in)
              `BSF_OP_EXT_PROG_LOAD: begin
                pm_rd_out <= 1'b1;
                pm_addr_out <= ext_ptr;
                ext_reg <= ext_ptr_inc[23:16];
                z_wr_out <= 1'b1;
                z_wr_data_out <= ext_ptr_inc[15:0];
                state_reg <= ST_WAIT;
              end
              `BSF_OP_PROG_MEM_STORE: begin
                // one cycle chosen here; the memory paces itself
                // the extension is not used: Z alone picks the word
                pm_wr_out <= 1'b1;
                pm_addr_out <= {8'h00, z_ptr_in};
                pm_wr_data_out <= r1r0_word_in;
                op_done_out <= 1'b1;
              end
              `BSF_OP_PORT_IN: begin
                // io data is combinational from the addressed port
                reg_wr_out <= 1'b1;
                reg_wr_data_out <= io_rd_data_in;
                io_rd_out <= 1'b1;
                op_done_out <= 1'b1;
              end
              `BSF_OP_PORT_OUT: begin
                io_wr_out <= 1'b1;
                io_wr_data_out <= reg_src_in;
                op_done_out <= 1'b1;
              end
              `BSF_OP_PUSH: begin
                stack_push_out <= 1'b1;
                stack_wr_data_out <= reg_src_in;
                state_reg <= ST_LAST;
              end
              `BSF_OP_POP: begin
                stack_pop_out <= 1'b1;
                state_reg <= ST_LAST;
              end
              `BSF_OP_IO_BIT_SET,
              `BSF_OP_IO_BIT_CLEAR: begin
                io_rd_out <= 1'b1;
                state_reg <= ST_LAST;
              end
              `BSF_OP_LOGIC_SHIFT_LEFT,
              `BSF_OP_LOGIC_SHIFT_RIGHT,
              `BSF_OP_ROTATE_LEFT_CARRY,
              `BSF_OP_ROTATE_RIGHT_CARRY,
              `BSF_OP_ARITH_SHIFT_RIGHT,
              `BSF_OP_NIBBLE_SWAP: begin
                reg_wr_out <= 1'b1;
                reg_wr_data_out <= sh_result;
                op_done_out <= 1'b1;
              end
              `BSF_OP_TRANSFER_FLAG_TO_BIT: begin
                reg_wr_out <= 1'b1;
                reg_wr_data_out <= status_reg[`BSF_FLAG_T] ?
                  (reg_dst_in | onehot8(bit_sel_in)) :
                  (reg_dst_in & ~onehot8(bit_sel_in));
                op_done_out <= 1'b1;
              end
              default: begin
                op_done_out <= 1'b1;
              end
            endcase
          end
        end
        ST_WAIT: begin
          // only the extended load passes through here
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h2) begin
            state_reg <= ST_LAST;
          end
        end
        ST_LAST: begin
          // bit ops are read-modify-write and not atomic: a port
          // that changes between read and write loses that change
          state_reg <= ST_IDLE;
          op_done_out <= 1'b1;
          cnt_reg <= 2'h0;
          if (op_reg == `BSF_OP_EXT_PROG_LOAD) begin
            // memory data is held stable until the final cycle
            reg_wr_out <= 1'b1;
            reg_wr_data_out <= pm_rd_data_in;
          end else if (op_reg == `BSF_OP_POP) begin
            reg_wr_out <= 1'b1;
            reg_wr_data_out <= stack_rd_data_in;
          end else if (op_reg == `BSF_OP_IO_BIT_SET) begin
            io_wr_out <= 1'b1;
            io_addr_out <= io_reg;
            io_wr_data_out <= io_rd_data_in | onehot8(bit_reg);
          end else if (op_reg == `BSF_OP_IO_BIT_CLEAR) begin
            io_wr_out <= 1'b1;
            io_addr_out <= io_reg;
            io_wr_data_out <= io_rd_data_in & ~onehot8(bit_reg);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // bsf_exec

/* File: test/bsf_exec_checker.sv */
// concurrent checks on the executor ports
`timescale 1ns/10ps
`include "bsf_map.vh"
module bsf_exec_checker (
  // clock, reset and issue
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire op_valid_in,
  input wire [4:0] op_code_in,
  input wire [2:0] bit_sel_in,
  input wire op_ready_out,
  input wire op_done_out,
  // operands and results
  input wire [7:0] reg_src_in,
  input wire [7:0] reg_dst_in,
  input wire [15:0] z_ptr_in,
  input wire reg_wr_out,
  input wire [7:0] reg_wr_data_out,
  input wire [15:0] z_wr_data_out,
  input wire pm_rd_out,
  input wire [23:0] pm_addr_out,
  input wire io_rd_out,
  input wire io_wr_out,
  input wire [7:0] io_wr_data_out,
  input wire [7:0] io_rd_data_in,
  input wire stack_pop_out,
  input wire [7:0] stack_wr_data_out,
  input wire [7:0] prog_addr_extension_out,
  input wire [7:0] status_register_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take(logic [4:0] op);
    op_valid_in && op_ready_out && op_code_in == op;
  endsequence
  // extended load: read strobe, a pad cycle, then write-back with done
  sequence s_ext_tail;
    pm_rd_out ##2 (reg_wr_out && op_done_out);
  endsequence
  chk_ext_steps: assert property (
    s_take(`BSF_OP_EXT_PROG_LOAD) |=> s_ext_tail)
    else $error("extended load steps wrong");
  chk_ext_addr: assert property (
    s_take(`BSF_OP_EXT_PROG_LOAD) |=> pm_addr_out ==
      {$past(prog_addr_extension_out), $past(z_ptr_in)} &&
      z_wr_data_out == $past(z_ptr_in) + 16'h0001)
    else $error("extended load address wrong");
  chk_push_data: assert property (
    s_take(`BSF_OP_PUSH) |=> !op_done_out ##1
      (op_done_out && stack_wr_data_out == $past(reg_src_in, 2)))
    else $error("push wrong");
  chk_pop_steps: assert property (
    s_take(`BSF_OP_POP) |=> (stack_pop_out && !op_ready_out) ##1
      (reg_wr_out && op_done_out))
    else $error("pop steps wrong");
  chk_io_set: assert property (
    s_take(`BSF_OP_IO_BIT_SET) |=> io_rd_out ##1 (io_wr_out &&
      io_wr_data_out == ($past(io_rd_data_in) |
        (8'h01 << $past(bit_sel_in, 2)))))
    else $error("io bit set wrong");
  chk_shl_carry: assert property (
    s_take(`BSF_OP_LOGIC_SHIFT_LEFT) |=> op_done_out &&
      reg_wr_data_out == {$past(reg_dst_in[6:0]), 1'b0} &&
      status_register_out[0] == $past(reg_dst_in[7]))
    else $error("left shift wrong");
  chk_swap_flags: assert property (
    s_take(`BSF_OP_NIBBLE_SWAP) |=> $stable(status_register_out) &&
      reg_wr_data_out == {$past(reg_dst_in[3:0]), $past(reg_dst_in[7:4])})
    else $error("swap wrong");
  chk_status_set: assert property (
    s_take(`BSF_OP_STATUS_BIT_SET) |=> status_register_out ==
      ($past(status_register_out) | (8'h01 << $past(bit_sel_in))))
    else $error("status bit set wrong");
  chk_bit_to_t: assert property (
    s_take(`BSF_OP_BIT_TO_TRANSFER_FLAG) |=>
      status_register_out[6] == $past(reg_src_in[bit_sel_in]))
    else $error("transfer flag store wrong");
endmodule // bsf_exec_checker

/* File: test/test_bsf_exec.sv */
// self-checking bench for the bit, shift and flag executor
`timescale 1ns/10ps
`include "bsf_map.vh"
module test_bsf_exec;
  reg core_clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg op_valid_in = 1'b0;
  reg [4:0] op_code_in = 5'h00;
  reg [2:0] bit_sel_in = 3'h0;
  reg [5:0] io_addr_in = 6'h00;
  reg [7:0] reg_src_in = 8'h00;
  reg [7:0] reg_dst_in = 8'h00;
  reg [15:0] z_ptr_in = 16'h0000;
  reg [15:0] r1r0_word_in = 16'h0000;
  reg [7:0] pm_rd_data_in = 8'h00;
  reg [7:0] io_rd_data_in = 8'h00;
  reg [7:0] stack_rd_data_in = 8'h00;
  reg ext_wr_in = 1'b0;
  reg [7:0] ext_wr_data_in = 8'h00;
  wire op_ready_out, op_done_out, reg_wr_out, z_wr_out, pm_rd_out, pm_wr_out;
  wire io_rd_out, io_wr_out, stack_push_out, stack_pop_out;
  wire [7:0] reg_wr_data_out, io_wr_data_out, stack_wr_data_out;
  wire [7:0] prog_addr_extension_out, status_register_out;
  wire [15:0] z_wr_data_out, pm_wr_data_out;
  wire [23:0] pm_addr_out;
  wire [5:0] io_addr_out;
  integer n_mismatch = 0;
  integer comparisons = 0;
  integer cyc_cnt = 0;
  integer ncyc, i, ec;
  reg [31:0] seed = 32'hE35B7846;
  reg [7:0] sr, ext, got_reg, got_io, got_stk, res;
  reg [15:0] got_z, got_pw, exp_z;
  reg [23:0] got_pa;
  reg nc, sh;

  bsf_exec i_dut (.*);

  always #12.5 core_clk_in = ~core_clk_in;
  // hang guard well above the under one thousand cycles the run needs
  always @(posedge core_clk_in) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: run timed out", $time);
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic [7:0] r8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r8 = seed[7:0];
  endfunction
  // expected port byte after a bit set or clear
  function [7:0] io_bit_exp(input set, input [7:0] v, input [2:0] b);
    io_bit_exp = set ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
  endfunction
  task check(input [23:0] got, input [23:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("counts: %0d compared, %0d mismatched", comparisons,
               n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // operands stay put through the op so expectations read them after
  task do_op(input [4:0] op, input [2:0] b, input [7:0] d, input [15:0] z);
    integer k;
    begin
      @(posedge core_clk_in);
      op_valid_in <= 1'b1;
      op_code_in <= op;
      bit_sel_in <= b;
      reg_dst_in <= d;
      z_ptr_in <= z;
      reg_src_in <= r8();
      io_addr_in <= r8();
      io_rd_data_in <= r8();
      stack_rd_data_in <= r8();
      pm_rd_data_in <= r8();
      r1r0_word_in <= {r8(), r8()};
      {got_reg, got_io, got_stk, got_z, got_pw, got_pa} = 'x;
      @(posedge core_clk_in);
      op_valid_in <= 1'b0;
      ncyc = 0;
      for (k = 0; k < 5 && ncyc == 0; k = k + 1) begin
        #1;
        if (reg_wr_out === 1'b1) got_reg = reg_wr_data_out;
        if (io_wr_out === 1'b1) got_io = io_wr_data_out;
        if (stack_push_out === 1'b1) got_stk = stack_wr_data_out;
        if (z_wr_out === 1'b1) got_z = z_wr_data_out;
        if (pm_rd_out === 1'b1 || pm_wr_out === 1'b1) got_pa = pm_addr_out;
        if (pm_wr_out === 1'b1) got_pw = pm_wr_data_out;
        if (op_done_out === 1'b1) ncyc = k + 1;
        else @(posedge core_clk_in);
      end
      ec = 1;
      sh = 1'b0;
      res = d;
      case (op)
        `BSF_OP_EXT_PROG_LOAD: begin
          ec = 3;
          check(got_pa, {ext, z});
          check(got_reg, pm_rd_data_in);
          {ext, exp_z} = {ext, z} + 24'h000001;
          check(got_z, exp_z);
          check(prog_addr_extension_out, ext);
        end
        `BSF_OP_PROG_MEM_STORE: begin
          check(got_pa[15:0], z);
          check(got_pw, r1r0_word_in);
        end
        `BSF_OP_PORT_IN: check(got_reg, io_rd_data_in);
        `BSF_OP_PORT_OUT: begin
          check(got_io, reg_src_in);
          check(io_addr_out, io_addr_in);
        end
        `BSF_OP_PUSH: begin
          ec = 2;
          check(got_stk, reg_src_in);
        end
        `BSF_OP_POP: begin
          ec = 2;
          check(got_reg, stack_rd_data_in);
        end
        `BSF_OP_IO_BIT_SET, `BSF_OP_IO_BIT_CLEAR: begin
          ec = 2;
          res = io_bit_exp(op == `BSF_OP_IO_BIT_SET, io_rd_data_in, b);
          check(got_io, res);
          check(io_addr_out, io_addr_in);
        end
        `BSF_OP_LOGIC_SHIFT_LEFT: {sh, nc, res} = {1'b1, d, 1'b0};
        `BSF_OP_LOGIC_SHIFT_RIGHT: {sh, res, nc} = {2'b10, d};
        `BSF_OP_ROTATE_LEFT_CARRY: {sh, nc, res} = {1'b1, d, sr[0]};
        `BSF_OP_ROTATE_RIGHT_CARRY: {sh, res, nc} = {1'b1, sr[0], d};
        `BSF_OP_ARITH_SHIFT_RIGHT: {sh, res, nc} = {1'b1, d[7], d};
        `BSF_OP_NIBBLE_SWAP: check(got_reg, {d[3:0], d[7:4]});
        `BSF_OP_STATUS_BIT_SET: sr[b] = 1'b1;
        `BSF_OP_STATUS_BIT_CLEAR: sr[b] = 1'b0;
        `BSF_OP_BIT_TO_TRANSFER_FLAG: sr[6] = reg_src_in[b];
        `BSF_OP_TRANSFER_FLAG_TO_BIT: begin
          res[b] = sr[6];
          check(got_reg, res);
        end
        `BSF_OP_CARRY_SET, `BSF_OP_CARRY_CLEAR: sr[0] = op[0];
        `BSF_OP_NEGATIVE_SET, `BSF_OP_NEGATIVE_CLEAR: sr[2] = op[0];
        `BSF_OP_ZERO_FLAG_SET, `BSF_OP_ZERO_FLAG_CLEAR: sr[1] = op[0];
        `BSF_OP_IRQ_ENABLE_SET, `BSF_OP_IRQ_ENABLE_CLEAR: sr[7] = op[0];
        default: ;
      endcase
      if (sh) begin
        sr[3:0] = {res[7] ^ nc, res[7], res == 8'h00, nc};
        sr[4] = sr[2] ^ sr[3];
        check(got_reg, res);
      end
      check(ncyc, ec);
      check(status_register_out, sr);
    end
  endtask
  task load_ext(input [7:0] v);
    begin
      @(posedge core_clk_in);
      ext_wr_in <= 1'b1;
      ext_wr_data_in <= v;
      @(posedge core_clk_in);
      ext_wr_in <= 1'b0;
      ext = v;
      #1;
      check(prog_addr_extension_out, v);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sr = 8'h00;
    ext = 8'h00;
    repeat (20) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    check(status_register_out, 8'h00);
    // post-increment carrying out of Z into the extension
    load_ext(8'h7F);
    do_op(`BSF_OP_EXT_PROG_LOAD, 3'h0, 8'h00, 16'hFFFF);
    $display("extended load corner done");
    for (i = 0; i < 24; i = i + 1)
      do_op(`BSF_OP_LOGIC_SHIFT_LEFT + i / 4, 3'h0,
            i[1] ? 8'h80 : {7'h00, i[0]}, 16'h0000);
    $display("shift corners done");
    for (i = 0; i < 16; i = i + 1)
      do_op(`BSF_OP_STATUS_BIT_SET + i[0], i / 2, r8(), 16'h0000);
    for (i = 0; i < 8; i = i + 1)
      do_op(`BSF_OP_CARRY_SET + i, 3'h0, r8(), 16'h0000);
    $display("flag ops done");
    load_ext(r8());
    for (i = 0; i < 300; i = i + 1)
      do_op(5'h01 + r8() % 26, r8(), r8(), {r8(), r8()});
    $display("random ops done");
    print_verdict;
  end
endmodule // test_bsf_exec

bind bsf_exec bsf_exec_checker i_chk (.*);
